// *** hw/bcd_sub_pkg.sv ***
// Shared types and constants for the BCD subtract unit
package bcd_sub_pkg;

  // ****************************************
  // Operation codes
  // ****************************************
  localparam logic [9:0] FC_BCD_SUB_SINGLE        = 10'h19E;
  localparam logic [9:0] FC_BCD_SUB_DOUBLE        = 10'h19F;
  localparam logic [9:0] FC_BCD_SUB_BORROW_SINGLE = 10'h1A0;
  localparam logic [9:0] FC_BCD_SUB_BORROW_DOUBLE = 10'h1A1;
  localparam logic [9:0] FC_CLEAR_BORROW_OP       = 10'h029;

  // ****************************************
  // Widths and reset values
  // ****************************************
  localparam int         WORD_W        = 16;
  localparam int         DIGITS        = 4;
  localparam logic       BORROW_RESET  = 1'b0;
  localparam logic       FLAG_RESET    = 1'b0;
  localparam logic [3:0] DIGIT_MAX     = 4'h9;
  localparam logic [3:0] DIGIT_RADIX   = 4'hA;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic        valid;
    logic [9:0]  code;
    logic [15:0] first_lo;
    logic [15:0] first_hi;
    logic [15:0] second_lo;
    logic [15:0] second_hi;
  } op_req_t;

  typedef struct packed {
    logic        done;
    logic        write_lo;
    logic        write_hi;
    logic [15:0] outcome_lo;
    logic [15:0] outcome_hi;
    logic        invalid_digit_flag;
    logic        zero_result_flag;
    logic        borrow_flag;
  } op_res_t;

endpackage

// *** hw/bcd_subtract_unit.sv ***
// BCD subtract unit: four subtract forms and borrow clear
//
// Behaviour
// RULE1: single form subtracts 4-digit second from first into one outcome word
// RULE2: double form subtracts 8-digit operands into two outcome words
// RULE3: single borrow form also subtracts incoming borrow_flag
// RULE4: double borrow form also subtracts incoming borrow_flag
// RULE5: negative difference is written as the 10's complement
// RULE6: invalid_digit_flag set if any operand word is not BCD, else cleared
// RULE7: a digit above nine is invalid; then outcome words are not written
// RULE8: zero_result_flag set when whole result is zero, else cleared
// RULE9: borrow_flag set on borrow out of top digit, else cleared
// RULE10: first smaller than subtrahend gives complement result and borrow set
// RULE11: clear_borrow_op drives borrow_flag to zero
// RULE12: software recovers magnitude by subtracting result from zero on borrow
// RULE13: zero minus a complement value B yields 10000 minus B
// RULE14: lower word holds low four digits, next word the high four
`timescale 1ns/1ps
module bcd_subtract_unit (
  // Clock and reset
  input  wire logic                     I_SYS_CLK,
  input  wire logic                     I_RESET,
  // Request from the sequencer
  input  wire bcd_sub_pkg::op_req_t     I_REQ,
  // Result to data memory and flags
  output      bcd_sub_pkg::op_res_t     O_RES
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    bcd_sub_pkg::op_res_t res;
  } state_t;

  state_t state;
  state_t next_state;

  // Operation class of a request
  typedef struct packed {
    logic is_sub;
    logic is_double;
    logic uses_borrow;
    logic is_clear;
  } op_kind_t;

  // ****************************************
  // Functions
  // ****************************************
  // Map a request code to its operation class
  function automatic op_kind_t decode_op(input logic [9:0] code);
    op_kind_t kind_out;
    kind_out = '0;
    unique case (code)
      bcd_sub_pkg::FC_BCD_SUB_SINGLE: begin // see RULE1
        kind_out.is_sub = 1'b1;
      end
      bcd_sub_pkg::FC_BCD_SUB_DOUBLE: begin // see RULE2
        kind_out.is_sub    = 1'b1;
        kind_out.is_double = 1'b1;
      end
      bcd_sub_pkg::FC_BCD_SUB_BORROW_SINGLE: begin // see RULE3
        kind_out.is_sub      = 1'b1;
        kind_out.uses_borrow = 1'b1;
      end
      bcd_sub_pkg::FC_BCD_SUB_BORROW_DOUBLE: begin // see RULE4
        kind_out.is_sub      = 1'b1;
        kind_out.is_double   = 1'b1;
        kind_out.uses_borrow = 1'b1;
      end
      bcd_sub_pkg::FC_CLEAR_BORROW_OP: begin // see RULE11
        kind_out.is_clear = 1'b1;
      end
      default: begin
        // Codes of other units leave this one idle
        kind_out = '0;
      end
    endcase
    return kind_out;
  endfunction

  // One bit per digit field, set where the field holds 0 to 9
  function automatic logic [3:0] digit_ok_mask(input logic [15:0] w);
    logic [3:0] mask;
    mask = 4'h0;
    for (int d = 0; d < bcd_sub_pkg::DIGITS; d++) begin
      mask[d] = (w[4*d +: 4] <= bcd_sub_pkg::DIGIT_MAX); // see RULE7
    end
    return mask;
  endfunction

  // Subtract one digit and a borrow; bit 4 is borrow out
  function automatic logic [4:0] sub_digit(input logic [3:0] a,
                                           input logic [3:0] b,
                                           input logic       bin);
    logic [4:0] diff;
    logic       brw;
    diff = {1'b0, a} - {1'b0, b} - {4'h0, bin};
    brw  = diff[4];
    if (brw) begin
      // Borrow ten from the next digit, giving the complement digit
      diff = diff + {1'b0, bcd_sub_pkg::DIGIT_RADIX}; // see RULE5
    end
    return {brw, diff[3:0]};
  endfunction

  // Subtract one word digit by digit; bit 16 is borrow out
  function automatic logic [16:0] sub_word(input logic [15:0] a,
                                           input logic [15:0] b,
                                           input logic        bin);
    logic [4:0]  step;
    logic [15:0] out;
    logic        brw;
    out = 16'h0000;
    brw = bin;
    for (int d = 0; d < bcd_sub_pkg::DIGITS; d++) begin
      step          = sub_digit(a[4*d +: 4], b[4*d +: 4], brw);
      out[4*d +: 4] = step[3:0];
      brw           = step[4];
    end
    return {brw, out};
  endfunction

  // All four digits of a word are zero
  function automatic logic word_is_zero(input logic [15:0] w);
    return w == 16'h0000;
  endfunction

  // ****************************************
  // Datapath
  // ****************************************
  op_kind_t    kind;
  logic [3:0]  first_lo_mask;
  logic [3:0]  first_hi_mask;
  logic [3:0]  second_lo_mask;
  logic [3:0]  second_hi_mask;
  logic        lo_words_bcd;
  logic        hi_words_bcd;
  logic        all_bcd;
  logic        take_sub;
  logic        take_clear;
  logic        accept;
  logic        borrow_in;
  logic [16:0] low_part;
  logic [16:0] high_part;
  logic        top_borrow;
  logic [15:0] result_lo;
  logic [15:0] result_hi;
  logic        result_zero;

  assign kind           = decode_op(I_REQ.code);
  assign take_sub       = I_REQ.valid && kind.is_sub;
  assign take_clear     = I_REQ.valid && kind.is_clear;

  // Digit checks on every operand word
  assign first_lo_mask  = digit_ok_mask(I_REQ.first_lo);
  assign first_hi_mask  = digit_ok_mask(I_REQ.first_hi);
  assign second_lo_mask = digit_ok_mask(I_REQ.second_lo);
  assign second_hi_mask = digit_ok_mask(I_REQ.second_hi);
  assign lo_words_bcd   = (&first_lo_mask) && (&second_lo_mask); // see RULE6
  assign hi_words_bcd   = (&first_hi_mask) && (&second_hi_mask); // see RULE6
  // High words count only in the double forms
  assign all_bcd        = lo_words_bcd && (!kind.is_double || hi_words_bcd); // see RULE6
  assign accept         = take_sub && all_bcd; // see RULE7

  // Borrow chain from the flag left by the previous operation
  assign borrow_in      = kind.uses_borrow && state.res.borrow_flag; // see RULE3, RULE4
  assign low_part       = sub_word(I_REQ.first_lo, I_REQ.second_lo, borrow_in); // see RULE14
  assign high_part      = sub_word(I_REQ.first_hi, I_REQ.second_hi, low_part[16]); // see RULE14
  assign top_borrow     = kind.is_double ? high_part[16] : low_part[16]; // see RULE9
  assign result_lo      = low_part[15:0];
  assign result_hi      = kind.is_double ? high_part[15:0] : 16'h0000;
  assign result_zero    = word_is_zero(result_lo) && word_is_zero(result_hi); // see RULE8

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_state              = state;
    // Strobes last one cycle
    next_state.res.done     = take_sub || take_clear;
    next_state.res.write_lo = accept; // see RULE1, RULE7
    next_state.res.write_hi = accept && kind.is_double; // see RULE2, RULE7
    // Error flag follows every subtract, valid or not
    if (take_sub) begin
      next_state.res.invalid_digit_flag = !all_bcd; // see RULE6, RULE7
    end
    // Outcome words and result flags only on a valid subtract
    if (accept) begin
      next_state.res.outcome_lo       = result_lo; // see RULE5, RULE14
      next_state.res.outcome_hi       = result_hi; // see RULE14
      // Zero minus a complement restores magnitude naturally
      next_state.res.borrow_flag      = top_borrow; // see RULE9, RULE10, RULE13
      next_state.res.zero_result_flag = result_zero; // see RULE8
    end
    // Clear leaves the other flags alone
    if (take_clear) begin
      next_state.res.borrow_flag = 1'b0; // see RULE11
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RESET) begin
      state                        <= '0;
      state.res.borrow_flag        <= bcd_sub_pkg::BORROW_RESET;
      state.res.invalid_digit_flag <= bcd_sub_pkg::FLAG_RESET;
      state.res.zero_result_flag   <= bcd_sub_pkg::FLAG_RESET;
    end else begin
      state <= next_state;
    end
  end

  assign O_RES = state.res;

endmodule

// *** tb/bcd_subtract_unit_properties.sv ***
// Checker for the BCD subtract unit
`timescale 1ns/1ps
module bcd_subtract_unit_properties (
  input wire logic                 I_SYS_CLK,
  input wire logic                 I_RESET,
  input wire bcd_sub_pkg::op_req_t I_REQ,
  input wire bcd_sub_pkg::op_res_t O_RES
);
  wire       v = I_REQ.valid;
  wire [9:0] c = I_REQ.code;
  wire       bad = O_RES.done && O_RES.invalid_digit_flag;
  default clocking @(posedge I_SYS_CLK); endclocking
  default disable iff (I_RESET);
  a_clear_drops_borrow: assert property (
    v && c == bcd_sub_pkg::FC_CLEAR_BORROW_OP |=> !O_RES.borrow_flag) else $error("borrow kept");
  a_single_lo_only: assert property (
    v && !c[0] && c[8] |=> !O_RES.write_hi) else $error("high word written");
  a_bad_no_write: assert property (
    bad |-> !O_RES.write_lo && !O_RES.write_hi) else $error("invalid result written");
  a_bad_keeps_borrow: assert property (
    bad && $past(c) != bcd_sub_pkg::FC_CLEAR_BORROW_OP |-> $stable(O_RES.borrow_flag))
    else $error("borrow changed on invalid");
  a_bad_keeps_zero: assert property (
    bad && $past(c) != bcd_sub_pkg::FC_CLEAR_BORROW_OP |-> $stable(O_RES.zero_result_flag))
    else $error("zero flag changed on invalid");
  a_zero_flag_match: assert property (
    O_RES.write_lo |-> O_RES.zero_result_flag == ({O_RES.outcome_hi, O_RES.outcome_lo} == 32'h0))
    else $error("zero flag wrong");
  a_write_valid_bcd: assert property (
    O_RES.write_lo |-> !O_RES.invalid_digit_flag) else $error("invalid flag with write");
  a_hi_with_lo: assert property (
    O_RES.write_hi |-> O_RES.write_lo) else $error("high word alone");
  a_done_has_cause: assert property (
    O_RES.done |-> $past(v)) else $error("done without request");
  a_outcome_held: assert property (
    !O_RES.write_lo |-> $stable(O_RES.outcome_lo)) else $error("outcome changed");
  a_small_first_borrow: assert property (
    v && c == bcd_sub_pkg::FC_BCD_SUB_SINGLE && I_REQ.first_lo < I_REQ.second_lo
    |=> O_RES.borrow_flag || O_RES.invalid_digit_flag) else $error("borrow missing");
endmodule
bind bcd_subtract_unit bcd_subtract_unit_properties u_props (.I_SYS_CLK(I_SYS_CLK),
  .I_RESET(I_RESET), .I_REQ(I_REQ), .O_RES(O_RES));

// *** tb/bcd_mem_model.sv ***
// Data memory words written by the unit
`timescale 1ns/1ps
module bcd_mem_model (
  input  wire logic                 i_clk,
  input  wire bcd_sub_pkg::op_res_t i_res,
  output logic [15:0]               o_word_lo = 16'h0,
  output logic [15:0]               o_word_hi = 16'h0
);
  always @(posedge i_clk) begin
    if (i_res.write_lo) o_word_lo <= i_res.outcome_lo;
    if (i_res.write_hi) o_word_hi <= i_res.outcome_hi;
  end
endmodule

// *** tb/bcd_subtract_unit_tb.sv ***
// Testbench for the BCD subtract unit
`timescale 1ns/1ps
module bcd_subtract_unit_tb;
  logic                 I_SYS_CLK = 1'b0;
  logic                 I_RESET   = 1'b1;
  bcd_sub_pkg::op_req_t I_REQ     = '0;
  bcd_sub_pkg::op_res_t O_RES;
  logic [15:0]          word_lo;
  logic [15:0]          word_hi;
  int                   error_cnt = 0;
  int                   num_checks = 0;
  bcd_subtract_unit u_dut (.I_SYS_CLK(I_SYS_CLK), .I_RESET(I_RESET), .I_REQ(I_REQ), .O_RES(O_RES));
  bcd_mem_model u_mem (.i_clk(I_SYS_CLK), .i_res(O_RES), .o_word_lo(word_lo), .o_word_hi(word_hi));
  initial begin
    forever #50 I_SYS_CLK = ~I_SYS_CLK;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Flags f are done, invalid, zero, borrow
  task automatic op(input logic [9:0] c, input logic [31:0] a, input logic [31:0] b,
                    input logic [31:0] m, input logic [3:0] f);
    logic w;
    @(posedge I_SYS_CLK);
    I_REQ <= '{1'b1, c, a[15:0], a[31:16], b[15:0], b[31:16]};
    @(posedge I_SYS_CLK);
    I_REQ.valid <= 1'b0;
    #1;
    w = f[3] && !f[2] && c[8];
    check({O_RES.done, O_RES.invalid_digit_flag, O_RES.zero_result_flag, O_RES.borrow_flag}, f);
    check({O_RES.write_lo, O_RES.write_hi}, {w, w && c[0]});
    @(posedge I_SYS_CLK);
    #1;
    check({word_hi, word_lo}, m);
  endtask
  task automatic t_single;
    op(10'h19E, 32'h0100, 32'h0001, 32'h0099, 4'h8);
    op(10'h19E, 32'h1234, 32'h1234, 32'h0000, 4'hA);
    op(10'h19E, 32'h0000, 32'h0001, 32'h9999, 4'h9);
    check(O_RES.borrow_flag, 1'h1);
    if (O_RES.borrow_flag === 1'b1) begin
      op(10'h19E, 32'h0, 32'h9999, 32'h0001, 4'h9);
    end
  endtask
  // Mid-run reset with borrow set and an outcome held
  task automatic t_reset;
    @(posedge I_SYS_CLK);
    I_RESET <= 1'b1;
    repeat (2) @(posedge I_SYS_CLK);
    I_RESET <= 1'b0;
    #1;
    check({O_RES.done, O_RES.write_lo, O_RES.write_hi}, 3'h0);
    check({O_RES.invalid_digit_flag, O_RES.zero_result_flag, O_RES.borrow_flag},
          {bcd_sub_pkg::FLAG_RESET, bcd_sub_pkg::FLAG_RESET, bcd_sub_pkg::BORROW_RESET});
    check({O_RES.outcome_hi, O_RES.outcome_lo}, 32'h00000000);
  endtask
  task automatic t_double;
    op(10'h19F, 32'h09583960, 32'h17072641, 32'h92511319, 4'h9);
    op(10'h1A1, 32'h0, 32'h0, 32'h99999999, 4'h9);
  endtask
  task automatic t_borrow;
    op(10'h029, 32'h0, 32'h0, 32'h99999999, 4'h8);
    op(10'h1A0, 32'h5, 32'h5, 32'h99990000, 4'hA);
    op(10'h19E, 32'h0, 32'h1, 32'h99999999, 4'h9);
    op(10'h1A0, 32'h10, 32'h9, 32'h99990000, 4'hA);
  endtask
  task automatic t_invalid;
    op(10'h19E, 32'h00A0, 32'h0001, 32'h99990000, 4'hE);
    op(10'h19F, 32'h1, 32'hF0000000, 32'h99990000, 4'hE);
    op(10'h1A1, 32'h2, 32'h1, 32'h00000001, 4'h8);
    op(10'h3FF, 32'h0, 32'h0, 32'h00000001, 4'h0);
  endtask
  task automatic end_sim;
    $display("Checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #200000;
    error_cnt++;
    end_sim();
  end
  initial begin
    repeat (3) @(posedge I_SYS_CLK);
    I_RESET <= 1'b0;
    t_single();
    t_reset();
    t_double();
    t_borrow();
    t_invalid();
    end_sim();
  end
endmodule
